// ===== sd_seq_pkg.sv
// constants, modes and states shared by the converter sequencer files
package sd_seq_pkg;
	localparam int unsigned CLK_HZ     = 100_000_000;
	localparam int unsigned RATE12_SPS = 192_000;
	localparam int unsigned RATE8_SPS  = 384_000;
	// one conversion period in clocks; a longest time, so rounded down
	localparam logic [9:0]  DEC12_CYC  = 10'(CLK_HZ / RATE12_SPS);
	localparam logic [9:0]  DEC8_CYC   = 10'(CLK_HZ / RATE8_SPS);
	localparam logic [1:0]  PRIME_CONVS = 2'h3;
	localparam int          RES_W      = 12;
	localparam int          RES8_W     = 8;
	localparam int          ACC_W      = 40;
	localparam int          SCALE_LSB  = 25;
	localparam int          SEL_W      = 4;
	localparam int          FIFO_DEPTH = 16;

	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_MULTI  = 2'h1,
		MODE_CONT   = 2'h2,
		MODE_TURBO  = 2'h3
	} mode_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h1,
		S_RUN  = 3'h2,
		S_WAIT = 3'h4
	} seq_state_t;
endpackage : sd_seq_pkg

// ===== sd_pin_sync.sv
// three-stage synchroniser with agreement filter for an outside level
`timescale 1ns/1ps
module sd_pin_sync (
	input  wire logic ref_clk_in,
	input  wire logic rst_n_in,
	input  wire logic pin_in,
	output logic      level_out
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} sync_t;
	sync_t q;
	sync_t d;

	// first stage feeds only the second; a change counts once stages two and three agree
	always_comb begin
		d     = q;
		d.s1  = pin_in;
		d.s2  = q.s1;
		d.s3  = q.s2;
		if (q.s2 == q.s3) begin
			d.lvl = q.s3;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level_out = q.lvl;
endmodule : sd_pin_sync

// ===== sd_res_fifo.sv
// flip-flop fifo for conversion results, valid and ready on both sides
`timescale 1ns/1ps
module sd_res_fifo #(
	parameter int W = 12,
	parameter int D = 16
) (
	input  wire logic                 ref_clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 in_valid_in,
	output logic                      in_ready_out,
	input  wire logic [W-1:0]         in_data_in,
	output logic                      out_valid_out,
	input  wire logic                 out_ready_in,
	output logic [W-1:0]              out_data_out,
	output logic [$clog2(D+1)-1:0]    count_out
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D + 1);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [CW-1:0]       cnt;
	} fifo_t;
	fifo_t q;
	fifo_t d;
	logic  wr;
	logic  rd;

	// full and empty come straight from the count, so they are never optimistic
	assign in_ready_out  = (q.cnt != CW'(D));
	assign out_valid_out = (q.cnt != '0);
	assign out_data_out  = q.mem[q.rp];
	assign count_out     = q.cnt;

	always_comb begin
		d  = q;
		wr = in_valid_in & in_ready_out;
		rd = out_valid_out & out_ready_in;
		if (wr) begin
			d.mem[q.wp] = in_data_in;
			d.wp        = (q.wp == AW'(D - 1)) ? '0 : q.wp + AW'(1);
		end
		if (rd) begin
			d.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + AW'(1);
		end
		d.cnt = q.cnt + CW'(wr) - CW'(rd);
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : sd_res_fifo

// ===== sd_adc_seq.sv
// delta-sigma converter sequencer with sinc4 decimator and result fifo
// Contract
// - Four modes are selectable: single, multi, continuous and turbo multi.
// - Every mode starts on the start bit or on a rising external trigger.
// - A finished conversion sets a status flag and drives eoc high until the last buffered result is read.
// - Single mode waits idle, runs four conversions and reports only the fourth.
// - After the single result is read the sequencer idles until the next trigger.
// - Continuous mode gives its first result after three priming periods, then one per period.
// - Multi mode clears and re-primes the decimator before every sample.
// - Multi mode starts the next sample by itself after each one.
// - After an input selection change data is invalid until the fourth sample.
// - A fourth-order sinc filter turns the modulator bitstream into parallel results.
// - Twelve-bit results come at 192 ksps, eight-bit results at 384 ksps, same clock.
// - A done pulse marks the end of every reporting conversion, not of the priming ones, for interrupt or DMA use.
`timescale 1ns/1ps
module sd_adc_seq (
	input  wire logic                           ref_clk_in,
	input  wire logic                           arst_n_in,
	input  wire sd_seq_pkg::mode_t              mode_in,
	input  wire logic                           res_sel_in,
	input  wire logic [sd_seq_pkg::SEL_W-1:0]   chan_sel_in,
	input  wire logic                           start_bit_in,
	input  wire logic                           soc_pin_in,
	input  wire logic                           mod_bit_in,
	input  wire logic                           rd_ready_in,
	output logic                                rd_valid_out,
	output logic [sd_seq_pkg::RES_W-1:0]        rd_data_out,
	output logic                                eoc_out,
	output logic                                done_pulse_out,
	output logic                                busy_out,
	output logic                                overrun_out
);
	import sd_seq_pkg::*;

	localparam int FCW = $clog2(FIFO_DEPTH + 1);

	typedef struct packed {
		seq_state_t       st;
		logic [1:0]       cnt;
		logic [9:0]       dcnt;
		logic [ACC_W-1:0] i1;
		logic [ACC_W-1:0] i2;
		logic [ACC_W-1:0] i3;
		logic [ACC_W-1:0] i4;
		logic [ACC_W-1:0] z0;
		logic [ACC_W-1:0] z1;
		logic [ACC_W-1:0] z2;
		logic [ACC_W-1:0] z3;
		logic [RES_W-1:0] res;
		logic             pend;
		logic             done;
		logic             pulse;
		logic             ovr;
		logic             soc_prev;
		logic [SEL_W-1:0] sel;
	} seq_t;

	seq_t             q;
	seq_t             d;
	logic [1:0]       rst_sync_q;
	logic             rst_n;
	logic             soc_lvl;
	logic             trig;
	logic             tick;
	logic             clr;
	logic             sel_chg;
	logic [9:0]       period;
	logic [ACC_W-1:0] c1;
	logic [ACC_W-1:0] c2;
	logic [ACC_W-1:0] c3;
	logic [ACC_W-1:0] c4;
	logic [RES_W-1:0] scaled;
	logic             fifo_ready;
	logic             push_fire;
	logic             rd_fire;
	logic [FCW-1:0]   fifo_cnt;

	// reset is released through two flops so every register leaves reset on the same edge
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// external trigger comes from a pin, so it is filtered before edge detection
	sd_pin_sync u_soc_sync (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n),
		.pin_in     (soc_pin_in),
		.level_out  (soc_lvl)
	);

	// result buffer; a full buffer holds the pending result back
	sd_res_fifo #(
		.W (RES_W),
		.D (FIFO_DEPTH)
	) u_fifo (
		.ref_clk_in    (ref_clk_in),
		.rst_n_in      (rst_n),
		.in_valid_in   (q.pend),
		.in_ready_out  (fifo_ready),
		.in_data_in    (q.res),
		.out_valid_out (rd_valid_out),
		.out_ready_in  (rd_ready_in),
		.out_data_out  (rd_data_out),
		.count_out     (fifo_cnt)
	);

	assign push_fire = q.pend & fifo_ready;
	assign rd_fire   = rd_valid_out & rd_ready_in;

	// comb section of the sinc4 filter, evaluated on the decimation tick
	always_comb begin
		c1 = q.i4 - q.z0;
		c2 = c1 - q.z1;
		c3 = c2 - q.z2;
		c4 = c3 - q.z3;
		if (res_sel_in) begin
			scaled = {{(RES_W - RES8_W){1'b0}}, c4[SCALE_LSB +: RES8_W]};
		end else begin
			scaled = c4[SCALE_LSB +: RES_W];
		end
	end

	// sequencer, decimator and status flags
	always_comb begin
		d          = q;
		d.pulse    = 1'b0;
		d.ovr      = 1'b0;
		d.soc_prev = soc_lvl;
		d.sel      = chan_sel_in;
		clr        = 1'b0;
		trig       = start_bit_in | (soc_lvl & ~q.soc_prev);
		period     = res_sel_in ? DEC8_CYC : DEC12_CYC;
		tick       = (q.st == S_RUN) && (q.dcnt == period - 10'h1);
		sel_chg    = (q.sel != chan_sel_in);
		if (push_fire) begin
			d.pend = 1'b0;
		end
		// integrators run only while converting, wrap-around is harmless in a cic
		if (q.st == S_RUN) begin
			d.i1   = q.i1 + {{(ACC_W - 1){1'b0}}, mod_bit_in};
			d.i2   = q.i2 + q.i1;
			d.i3   = q.i3 + q.i2;
			d.i4   = q.i4 + q.i3;
			d.dcnt = tick ? 10'h0 : q.dcnt + 10'h1;
		end
		if (tick) begin
			d.z0 = q.i4;
			d.z1 = c1;
			d.z2 = c2;
			d.z3 = c3;
		end
		case (q.st)
			S_IDLE: begin
				// the conversion begins on the trigger with a clean decimator
				if (trig) begin
					d.st = S_RUN;
					clr  = 1'b1;
				end
			end
			S_RUN: begin
				// triggers are not looked at here, a running sequence is not restarted
				if (sel_chg) begin
					d.cnt = 2'h0;
				end else if (tick) begin
					if (q.cnt != PRIME_CONVS) begin
						d.cnt = q.cnt + 2'h1;
					end else begin
						d.pulse = 1'b1;
						if (q.pend && !push_fire) begin
							d.ovr = 1'b1; // the reader fell behind, this result is lost
						end else begin
							d.res  = scaled;
							d.pend = 1'b1;
						end
						case (mode_in)
							MODE_SINGLE: d.st = S_WAIT;
							MODE_CONT:   d.st = S_RUN;
							default:     clr  = 1'b1;
						endcase
					end
				end
			end
			S_WAIT: begin
				// standby again only once the result has left the buffer
				if (!q.pend && (fifo_cnt == '0)) begin
					d.st = S_IDLE;
				end
			end
			default: begin
				d.st = S_IDLE;
			end
		endcase
		if (clr) begin
			d.cnt  = 2'h0;
			d.dcnt = 10'h0;
			d.i1   = '0;
			d.i2   = '0;
			d.i3   = '0;
			d.i4   = '0;
			d.z0   = '0;
			d.z1   = '0;
			d.z2   = '0;
			d.z3   = '0;
		end
		// a new result sets the flag even in the cycle the last one is read
		d.done = push_fire | (q.done & ~(rd_fire && fifo_cnt == FCW'(1)));
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			q     <= '0;
			q.st  <= S_IDLE;
		end else begin
			q <= d;
		end
	end

	assign eoc_out        = q.done;
	assign done_pulse_out = q.pulse;
	assign busy_out       = (q.st != S_IDLE);
	assign overrun_out    = q.ovr;

	// a trigger in standby starts a sequence on the next edge
	property p_start;
		@(posedge ref_clk_in) disable iff (!rst_n)
		(q.st == S_IDLE && trig) |=> (q.st == S_RUN && q.cnt == 2'h0);
	endproperty
	a_start: assert property (p_start) else $error("trigger did not start");

	property p_ignore;
		@(posedge ref_clk_in) disable iff (!rst_n)
		(q.st == S_RUN && trig && !tick && !sel_chg) |=> $stable(q.cnt);
	endproperty
	a_ignore: assert property (p_ignore) else $error("busy trigger restarted");

	property p_fourth;
		@(posedge ref_clk_in) disable iff (!rst_n)
		$rose(q.pulse) |-> ($past(q.cnt) == PRIME_CONVS);
	endproperty
	a_fourth: assert property (p_fourth) else $error("result before priming");

	property p_hold;
		@(posedge ref_clk_in) disable iff (!rst_n)
		(q.done && !rd_fire) |=> q.done;
	endproperty
	a_hold: assert property (p_hold) else $error("done fell before read");

	property p_pulse;
		@(posedge ref_clk_in) disable iff (!rst_n)
		q.pulse |=> !q.pulse [*8];
	endproperty
	a_pulse: assert property (p_pulse) else $error("done pulse too long");

	property p_multi;
		@(posedge ref_clk_in) disable iff (!rst_n)
		(tick && q.cnt == PRIME_CONVS && !sel_chg && mode_in == MODE_MULTI)
			|=> (q.st == S_RUN && q.cnt == 2'h0 && q.i4 == '0);
	endproperty
	a_multi: assert property (p_multi) else $error("multi did not re-prime");

	property p_cont;
		@(posedge ref_clk_in) disable iff (!rst_n)
		(tick && q.cnt == PRIME_CONVS && !sel_chg && mode_in == MODE_CONT)
			|=> (q.st == S_RUN && q.cnt == PRIME_CONVS && q.pulse);
	endproperty
	a_cont: assert property (p_cont) else $error("continuous lost its pace");

	property p_sel;
		@(posedge ref_clk_in) disable iff (!rst_n)
		(q.st == S_RUN && sel_chg) |=> (q.cnt == 2'h0);
	endproperty
	a_sel: assert property (p_sel) else $error("selection change kept data");

	property p_single;
		@(posedge ref_clk_in) disable iff (!rst_n)
		(q.st == S_WAIT && (q.pend || fifo_cnt != '0)) |=> (q.st == S_WAIT);
	endproperty
	a_single: assert property (p_single) else $error("standby before transfer");

	property p_rate;
		@(posedge ref_clk_in) disable iff (!rst_n)
		(tick && res_sel_in) |-> (q.dcnt == DEC8_CYC - 10'h1);
	endproperty
	a_rate: assert property (p_rate) else $error("wrong eight-bit period");

	// turbo is decoded as a multi sample variant, so it re-primes the same way
	property p_turbo;
		@(posedge ref_clk_in) disable iff (!rst_n)
		(tick && q.cnt == PRIME_CONVS && !sel_chg && mode_in == MODE_TURBO)
			|=> (q.st == S_RUN && q.cnt == 2'h0 && q.i4 == '0);
	endproperty
	a_turbo: assert property (p_turbo) else $error("turbo did not re-prime");

	// a word entering the buffer raises the flag and shows as valid data
	property p_push;
		@(posedge ref_clk_in) disable iff (!rst_n)
		push_fire |=> (q.done && rd_valid_out);
	endproperty
	a_push: assert property (p_push) else $error("push did not raise done");

	// a result can only be dropped at the end of a conversion
	property p_ovr;
		@(posedge ref_clk_in) disable iff (!rst_n)
		q.ovr |-> q.pulse;
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun without a result");
endmodule : sd_adc_seq

// ===== sd_reader_model.sv
// reader model standing in for the cpu or dma side that drains results
`timescale 1ns/1ps
module sd_reader_model (
	input  wire logic ref_clk_in,
	input  wire logic stall_in,
	input  wire logic slow_in,
	output logic      rd_ready_out
);
	initial rd_ready_out = 1'b0;

	// ready moves just after an edge; slow mode takes a word only now and then
	always @(posedge ref_clk_in) begin
		#1 rd_ready_out = !stall_in && (!slow_in || $urandom_range(0, 2) == 0);
	end
endmodule : sd_reader_model

// ===== tb_sd_adc_seq.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_sd_adc_seq;
	import sd_seq_pkg::*;
	logic        clk, arst_n, res_sel, start, soc, mod, rd_ready, stall, slow, ones;
	logic        rd_valid, eoc, done, busy, ovr;
	logic [3:0]  chan;
	logic [11:0] rd_data;
	mode_t       mode;
	int          cyc, err_total, total_checks, ovr_seen, d, i, ev;
	longint      lp;
	int          exp_q[$];

	sd_adc_seq sd_adc_seq_i (.ref_clk_in(clk), .arst_n_in(arst_n), .mode_in(mode),
		.res_sel_in(res_sel), .chan_sel_in(chan), .start_bit_in(start), .soc_pin_in(soc),
		.mod_bit_in(mod), .rd_ready_in(rd_ready), .rd_valid_out(rd_valid),
		.rd_data_out(rd_data), .eoc_out(eoc), .done_pulse_out(done), .busy_out(busy),
		.overrun_out(ovr));
	sd_reader_model sd_reader_model_i (.ref_clk_in(clk), .stall_in(stall), .slow_in(slow),
		.rd_ready_out(rd_ready));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// cycle index of the latest rising edge, and a random bitstream
	always @(posedge clk) begin
		cyc++;
		#1 mod = ones ? 1'b1 : 1'($urandom);
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict

	// watcher: every done pulse takes the oldest note; a spare pulse is a fault
	always @(negedge clk) begin
		if (arst_n && done === 1'b1) begin
			if (exp_q.size() == 0) chk("spare done", 0, 1);
			else begin
				d = exp_q.pop_front();
				chk("done cycle", d, cyc);
			end
		end
		if (rd_valid === 1'b1) chk("eoc with data", 1, eoc);
		if (rd_valid === 1'b1 && rd_ready && res_sel) begin
			chk("upper bits", 0, rd_data[11:8]);
		end
		// all ones gives the full sinc4 gain, period to the fourth; one short after a clear
		if (rd_valid === 1'b1 && rd_ready && ones) begin
			lp = res_sel ? longint'(DEC8_CYC) : longint'(DEC12_CYC);
			ev = int'((lp * lp * lp * lp - 1) >> SCALE_LSB);
			chk("result", ev, rd_data);
		end
		if (ovr === 1'b1) ovr_seen++;
	end

	task automatic do_reset;
		arst_n = 1'b0;
		repeat (10) @(posedge clk);
		#1 arst_n = 1'b1;
		exp_q.delete();
		repeat (3) @(posedge clk);
		#1;
	endtask : do_reset

	// one triggered sequence; notes n expected done cycles, gap in periods
	task automatic run(input mode_t m, input logic r, input logic pin, input int n,
		input int gap);
		int c0, s, p, k;
		// a trigger is only taken in standby, so let the last sequence finish first
		for (k = 0; k < 50 && busy !== 1'b0; k++) begin
			@(posedge clk);
			#1;
		end
		mode = m;
		res_sel = r;
		chan = 4'($urandom);
		p = r ? int'(DEC8_CYC) : int'(DEC12_CYC);
		s = cyc + 1;
		if (pin) soc = 1'b1;
		else start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		for (k = 0; k < 20 && busy !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		soc = 1'b0;
		c0 = cyc - 1;
		// the pin edge is taken four edges late, behind its synchroniser and edge detector
		chk("busy rise", pin ? s + 4 : s, cyc);
		// the first result needs three priming periods plus its own
		c0 = c0 + (int'(PRIME_CONVS) + 1) * p + 1;
		exp_q.push_back(c0);
		for (k = 1; k < n; k++) exp_q.push_back(c0 + k * gap * p);
		if (m == MODE_SINGLE) begin
			repeat (100) @(posedge clk);
			#1 start = 1'b1;
			@(posedge clk);
			#1 start = 1'b0;
		end
		for (k = 0; k < 30000 && exp_q.size() > 0; k++) @(posedge clk);
		#1;
		if (exp_q.size() != 0) chk("missing done", 0, exp_q.size());
	endtask : run

	// a selection change two periods into priming restarts the count of four
	task automatic sel_switch(input int p);
		int e, k;
		e = cyc - 1;
		repeat (2 * p) @(posedge clk);
		#1 chan = chan + 4'h1;
		exp_q.push_back(e + 6 * p);
		exp_q.push_back(e + 10 * p);
		for (k = 0; k < 30000 && exp_q.size() > 0; k++) @(posedge clk);
		#1;
		if (exp_q.size() != 0) chk("missing done", 0, exp_q.size());
	endtask : sel_switch

	initial begin
		arst_n = 1'b0;
		mode = MODE_SINGLE;
		res_sel = 1'b1;
		chan = 4'h0;
		start = 1'b0;
		soc = 1'b0;
		mod = 1'b0;
		stall = 1'b0;
		slow = 1'b0;
		ones = 1'b0;
		void'($urandom(32'h4817));
		do_reset;
		// single mode by start bit then by pin, back to idle after the read
		run(MODE_SINGLE, 1'b1, 1'b0, 1, 0);
		run(MODE_SINGLE, 1'b0, 1'b1, 1, 0);
		for (i = 0; i < 50 && busy !== 1'b0; i++) @(posedge clk);
		#1 chk("idle after read", 0, busy);
		// multi and turbo restart by themselves, a full prime per sample
		slow = 1'b1;
		ones = 1'b1;
		run(MODE_MULTI, 1'b1, 1'b0, 3, 4);
		sel_switch(int'(DEC8_CYC));
		do_reset;
		ones = 1'b0;
		run(MODE_TURBO, 1'b0, 1'b1, 2, 4);
		do_reset;
		// continuous with the reader stalled until results are dropped
		slow = 1'b0;
		stall = 1'b1;
		ovr_seen = 0;
		run(MODE_CONT, 1'b1, 1'b0, 20, 1);
		chk("overrun seen", 1, ovr_seen > 0);
		stall = 1'b0;
		for (i = 0; i < 100 && rd_valid !== 1'b0; i++) @(posedge clk);
		#1 chk("drained", 0, rd_valid);
		chk("eoc cleared", 0, eoc);
		do_reset;
		give_verdict;
	end

	// hang guard well above the roughly 20000 cycles the tests need
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		$display("[FAIL] watchdog expected finish seen hang");
		give_verdict;
	end
endmodule : tb_sd_adc_seq
